/* design/ijht_pkg.sv */
// ijht_pkg: constants, register map and types for the indicator judge, hold and trigger block
// How it works
// - zero capture outside limit refused, error flagged
// - zero capture ignored while calibration lock off
// - clear-zero command removes captured offset
// - output select picks held or live value for the analogue code
// - limit pair accepted only if low below high
// - upper flag: set above high, clear below hysteresis
// - lower flag: set below low, clear above hysteresis
// - one hysteresis width; zero means no band
// - hold mode: off, sample, peak, bottom
// - sample mode: long press freezes, again releases
// - peak hold tracks maximum, discarded at hold off
// - bottom hold tracks minimum, discarded at hold off
// - clear button restarts peak or bottom tracking
// - zone retention keeps final value until clear
// - sample mode ignores zone retention and clear
// - auto zero captures zero when hold starts
// - rising trigger on upward crossing of level
// - falling trigger on downward crossing; disabled none
// - trigger position percent places point in window
// - analogue code linear from zero over span
// - analogue code updated at fixed rate, when enabled
// - stable flag after width held for duration
// - full voltage at zero plus span
package ijht_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned STAB_INTERVAL_MS = 100;
  localparam int unsigned STAB_INTERVAL_CYC = CLK_HZ / 1000 * STAB_INTERVAL_MS;
  localparam int unsigned DAC_RATE_HZ = 1000;
  localparam int unsigned DAC_PERIOD_CYC = CLK_HZ / DAC_RATE_HZ;
  localparam int unsigned TRIG_WINDOW_SAMPLES = 1000;
  localparam int unsigned PCT_FULL = 100;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ZERO_LIMIT = 8'h04;
  localparam logic [7:0] REG_LOW_STAGE = 8'h08;
  localparam logic [7:0] REG_HIGH_STAGE = 8'h0c;
  localparam logic [7:0] REG_HYST = 8'h10;
  localparam logic [7:0] REG_TRIG_LEVEL = 8'h14;
  localparam logic [7:0] REG_TRIG_POS = 8'h18;
  localparam logic [7:0] REG_DAC_ZERO = 8'h1c;
  localparam logic [7:0] REG_DAC_SPAN = 8'h20;
  localparam logic [7:0] REG_STAB_WIDTH = 8'h24;
  localparam logic [7:0] REG_STAB_TIME = 8'h28;
  localparam logic [7:0] REG_COMMAND = 8'h2c;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [7:0] REG_INDICATOR = 8'h34;
  localparam logic [7:0] REG_HELD = 8'h38;
  localparam logic [7:0] REG_OFFSET = 8'h3c;
  localparam logic [7:0] REG_DAC_CODE = 8'h40;
  localparam logic [7:0] REG_LOW_LIMIT = 8'h44;
  localparam logic [7:0] REG_HIGH_LIMIT = 8'h48;

  // command bits, status bits
  localparam int CMD_CLEAR_ZERO = 0;
  localparam int CMD_COMMIT_LIMITS = 1;
  localparam int ST_ZERO_ERR = 5;
  localparam int ST_LIMIT_ERR = 6;
  localparam int ST_TRIG_SEEN = 7;

  // reset values and analogue full-scale codes
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic signed [31:0] LOW_RESET = 32'sh0000_0000;
  localparam logic signed [31:0] HIGH_RESET = 32'sh0000_0001;
  localparam logic [15:0] DAC_FS_2V = 16'h7fff;
  localparam logic [15:0] DAC_FS_1V = 16'h3fff;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic signed [31:0] ijht_value_t;
  typedef logic signed [33:0] ijht_wide_t;

  typedef enum logic [1:0] {
    HOLD_OFF = 2'b00,
    HOLD_SAMPLE = 2'b01,
    HOLD_PEAK = 2'b10,
    HOLD_BOTTOM = 2'b11
  } ijht_hmode_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_HOLDING = 2'b01,
    HS_RETAIN = 2'b11
  } ijht_hstate_t;

  // control register layout, bit 31 downward to bit 0
  typedef struct packed {
    logic [20:0] unused;
    logic dac_range_2v;
    logic dac_enable;
    logic trig_falling;
    logic trig_enable;
    logic auto_zero;
    logic zone_retain;
    ijht_hmode_t hold_mode;
    logic out_live;
    logic zero_enable;
    logic cal_lock;
  } ijht_ctrl_t;

endpackage : ijht_pkg

/* design/ijht_top.sv */
// ijht_top: zero capture, limit judgment, hold, trigger, stability and analogue output code
module ijht_top
  import ijht_pkg::*;
#(
  parameter int unsigned STAB_CYC = STAB_INTERVAL_CYC,
  parameter int unsigned DAC_CYC = DAC_PERIOD_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // measured samples
  input wire logic sample_valid,
  input wire logic signed [31:0] sample_value,
  // operator button pulses
  input wire logic enter_button,
  input wire logic zero_button,
  input wire logic escape_button,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // judgment and status
  output logic upper_judgment_flag,
  output logic lower_judgment_flag,
  output logic stable,
  output logic signed [31:0] display_value,
  // trigger
  output logic trig_pulse,
  output logic [15:0] trig_pre_samples,
  // analogue output
  output logic dac_enable,
  output logic signed [15:0] dac_code
);

  ////////////////////////////////////////////////////////////////////////////////
  // storage
  ijht_ctrl_t ctrl_q;
  ijht_value_t zero_limit_q, low_stage_q, high_stage_q, low_q, high_q, hyst_q;
  ijht_value_t trig_level_q, dac_zero_q, dac_span_q, stab_width_q, stab_time_q;
  logic [6:0] trig_pos_q;
  logic wait_q;
  logic [31:0] rdata_q;
  ijht_value_t raw_q, ind_q, prev_q, offset_q, held_q, disp_q, snap_q;
  logic s1_q, have_prev_q;
  logic upper_q, lower_q, stable_q, trig_q;
  logic zero_err_q, limit_err_q, trig_seen_q;
  ijht_hstate_t hstate_q;
  logic [31:0] stab_tmr_q, stab_cnt_q, dac_tmr_q;
  logic dac_en_q;
  logic signed [15:0] dac_q;
  logic [15:0] pre_q;

  function automatic ijht_wide_t sx(input ijht_value_t v);
    sx = {{2{v[31]}}, v};
  endfunction : sx

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the access completes
  logic req, wr_go, cmd_go;
  assign req = avs_read || avs_write;
  assign wr_go = avs_write && !wait_q;
  assign cmd_go = wr_go && (avs_address == REG_COMMAND) && avs_byteenable[0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  // read mux, captured in the wait cycle
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (avs_address == REG_CTRL) begin
      rmux = ctrl_q;
    end else if (avs_address == REG_ZERO_LIMIT) begin
      rmux = zero_limit_q;
    end else if (avs_address == REG_LOW_STAGE) begin
      rmux = low_stage_q;
    end else if (avs_address == REG_HIGH_STAGE) begin
      rmux = high_stage_q;
    end else if (avs_address == REG_HYST) begin
      rmux = hyst_q;
    end else if (avs_address == REG_TRIG_LEVEL) begin
      rmux = trig_level_q;
    end else if (avs_address == REG_TRIG_POS) begin
      rmux = {25'h0, trig_pos_q};
    end else if (avs_address == REG_DAC_ZERO) begin
      rmux = dac_zero_q;
    end else if (avs_address == REG_DAC_SPAN) begin
      rmux = dac_span_q;
    end else if (avs_address == REG_STAB_WIDTH) begin
      rmux = stab_width_q;
    end else if (avs_address == REG_STAB_TIME) begin
      rmux = stab_time_q;
    end else if (avs_address == REG_STATUS) begin
      rmux = {24'h0, trig_seen_q, limit_err_q, zero_err_q, stable_q, (hstate_q == HS_RETAIN),
              (hstate_q == HS_HOLDING), lower_q, upper_q};
    end else if (avs_address == REG_INDICATOR) begin
      rmux = ind_q;
    end else if (avs_address == REG_HELD) begin
      rmux = held_q;
    end else if (avs_address == REG_OFFSET) begin
      rmux = offset_q;
    end else if (avs_address == REG_DAC_CODE) begin
      rmux = {{16{dac_q[15]}}, dac_q};
    end else if (avs_address == REG_LOW_LIMIT) begin
      rmux = low_q;
    end else if (avs_address == REG_HIGH_LIMIT) begin
      rmux = high_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      rdata_q <= rmux;
    end
  end

  // configuration writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      zero_limit_q <= '0;
      low_stage_q <= LOW_RESET;
      high_stage_q <= HIGH_RESET;
      hyst_q <= '0;
      trig_level_q <= '0;
      trig_pos_q <= 7'h00;
      dac_zero_q <= '0;
      dac_span_q <= '0;
      stab_width_q <= '0;
      stab_time_q <= '0;
    end else if (wr_go) begin
      if (avs_address == REG_CTRL) begin
        ctrl_q <= ijht_ctrl_t'(merge(ctrl_q, avs_writedata, avs_byteenable) & 32'h0000_07ff);
      end else if (avs_address == REG_ZERO_LIMIT) begin
        zero_limit_q <= merge(zero_limit_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_LOW_STAGE) begin
        low_stage_q <= merge(low_stage_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_HIGH_STAGE) begin
        high_stage_q <= merge(high_stage_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_HYST) begin
        hyst_q <= merge(hyst_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_TRIG_LEVEL) begin
        trig_level_q <= merge(trig_level_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_TRIG_POS && avs_byteenable[0]) begin
        if (avs_writedata[7:0] <= 8'(PCT_FULL)) begin
          trig_pos_q <= avs_writedata[6:0];
        end
      end else if (avs_address == REG_DAC_ZERO) begin
        dac_zero_q <= merge(dac_zero_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_DAC_SPAN) begin
        dac_span_q <= merge(dac_span_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_STAB_WIDTH) begin
        stab_width_q <= merge(stab_width_q, avs_writedata, avs_byteenable);
      end else if (avs_address == REG_STAB_TIME) begin
        stab_time_q <= merge(stab_time_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // limit pair commit with order check
  logic commit_ok, commit_bad;
  assign commit_ok = cmd_go && avs_writedata[CMD_COMMIT_LIMITS] && (low_stage_q < high_stage_q);
  assign commit_bad = cmd_go && avs_writedata[CMD_COMMIT_LIMITS] && !(low_stage_q < high_stage_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_q <= LOW_RESET;
      high_q <= HIGH_RESET;
    end else if (commit_ok) begin
      low_q <= low_stage_q;
      high_q <= high_stage_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sample stage: indicator value and per-sample strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      raw_q <= '0;
      ind_q <= '0;
      s1_q <= 1'b0;
    end else begin
      s1_q <= sample_valid;
      if (sample_valid) begin
        raw_q <= sample_value;
        ind_q <= sample_value - offset_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // digital zero capture and clear
  logic hold_start, in_limit, zero_req, zero_ok, zero_bad, clear_zero;
  ijht_wide_t raw_abs;
  ijht_hmode_t mode;
  assign mode = ctrl_q.hold_mode;
  assign hold_start = enter_button && (hstate_q != HS_HOLDING) && (mode != HOLD_OFF);
  assign raw_abs = raw_q[31] ? -sx(raw_q) : sx(raw_q);
  assign in_limit = raw_abs <= {2'b00, zero_limit_q};
  assign zero_req = (zero_button || (hold_start && ctrl_q.auto_zero))
                    && ctrl_q.cal_lock && ctrl_q.zero_enable;
  assign zero_ok = zero_req && in_limit;
  assign zero_bad = zero_req && !in_limit;
  assign clear_zero = cmd_go && avs_writedata[CMD_CLEAR_ZERO];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      offset_q <= '0;
    end else if (zero_ok) begin
      offset_q <= raw_q;
    end else if (clear_zero) begin
      offset_q <= '0;
    end
  end

  // sticky errors and trigger flag, set wins over write-one-clear
  logic st_clr;
  assign st_clr = wr_go && (avs_address == REG_STATUS) && avs_byteenable[0];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zero_err_q <= 1'b0;
      limit_err_q <= 1'b0;
      trig_seen_q <= 1'b0;
    end else begin
      zero_err_q <= zero_bad || (zero_err_q && !(st_clr && avs_writedata[ST_ZERO_ERR]));
      limit_err_q <= commit_bad || (limit_err_q && !(st_clr && avs_writedata[ST_LIMIT_ERR]));
      trig_seen_q <= trig_q || (trig_seen_q && !(st_clr && avs_writedata[ST_TRIG_SEEN]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // limit judgment with shared hysteresis
  ijht_wide_t hi_off, lo_on;
  assign hi_off = sx(high_q) - {2'b00, hyst_q};
  assign lo_on = sx(low_q) + {2'b00, hyst_q};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upper_q <= 1'b0;
      lower_q <= 1'b0;
    end else if (s1_q) begin
      if (!upper_q && (ind_q > high_q)) begin
        upper_q <= 1'b1;
      end else if (upper_q && (sx(ind_q) <= hi_off)) begin
        upper_q <= 1'b0;
      end
      if (!lower_q && (ind_q < low_q)) begin
        lower_q <= 1'b1;
      end else if (lower_q && (lo_on <= sx(ind_q))) begin
        lower_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hold state machine and held value
  logic extreme, esc_ok;
  ijht_value_t start_val;
  assign extreme = (mode == HOLD_PEAK) || (mode == HOLD_BOTTOM);
  assign esc_ok = escape_button && extreme;
  assign start_val = zero_ok ? '0 : ind_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hstate_q <= HS_IDLE;
      held_q <= '0;
    end else begin
      case (hstate_q)
        HS_IDLE, HS_RETAIN: begin
          if (mode == HOLD_OFF) begin
            hstate_q <= HS_IDLE;
          end else if (hold_start) begin
            hstate_q <= HS_HOLDING;
            held_q <= start_val;
          end else if (hstate_q == HS_RETAIN && (esc_ok || !extreme || !ctrl_q.zone_retain)) begin
            hstate_q <= HS_IDLE;
          end
        end
        HS_HOLDING: begin
          if (mode == HOLD_OFF) begin
            hstate_q <= HS_IDLE;
          end else if (enter_button) begin
            // zone retention only for peak and bottom
            hstate_q <= (extreme && ctrl_q.zone_retain) ? HS_RETAIN : HS_IDLE;
          end else if (esc_ok) begin
            held_q <= ind_q;
          end else if (s1_q && mode == HOLD_PEAK && ind_q > held_q) begin
            held_q <= ind_q;
          end else if (s1_q && mode == HOLD_BOTTOM && ind_q < held_q) begin
            held_q <= ind_q;
          end
        end
        default: begin
          hstate_q <= HS_IDLE;
        end
      endcase
    end
  end

  // shown value: held while holding or retained, else live
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      disp_q <= '0;
    end else begin
      disp_q <= (hstate_q == HS_IDLE) ? ind_q : held_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trigger slope detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
      have_prev_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      if (s1_q) begin
        prev_q <= ind_q;
        have_prev_q <= 1'b1;
        if (ctrl_q.trig_enable && have_prev_q) begin
          if (!ctrl_q.trig_falling) begin
            trig_q <= (prev_q < trig_level_q) && (ind_q >= trig_level_q);
          end else begin
            trig_q <= (prev_q > trig_level_q) && (ind_q <= trig_level_q);
          end
        end
      end
    end
  end

  // samples of the window that precede the trigger point
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= 16'((32'(trig_pos_q) * TRIG_WINDOW_SAMPLES) / PCT_FULL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stability detection against a snapshot taken each interval
  ijht_wide_t sdiff, sabs;
  assign sdiff = sx(ind_q) - sx(snap_q);
  assign sabs = sdiff[33] ? -sdiff : sdiff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stab_tmr_q <= '0;
      stab_cnt_q <= '0;
      snap_q <= '0;
      stable_q <= 1'b0;
    end else if (stab_tmr_q >= 32'(STAB_CYC - 1)) begin
      stab_tmr_q <= '0;
      snap_q <= ind_q;
      if (sabs < {2'b00, stab_width_q}) begin
        if (stab_cnt_q < stab_time_q) begin
          stab_cnt_q <= stab_cnt_q + 32'h0000_0001;
        end
        stable_q <= (stab_cnt_q + 32'h0000_0001) >= stab_time_q;
      end else begin
        stab_cnt_q <= '0;
        stable_q <= 1'b0;
      end
    end else begin
      stab_tmr_q <= stab_tmr_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // analogue output code, linear from zero setting over span
  ijht_value_t dac_src;
  ijht_wide_t ddiff;
  logic [15:0] fs_code;
  logic signed [63:0] dnum, dquot;
  logic signed [15:0] dclamp;
  assign dac_src = ctrl_q.out_live ? ind_q : disp_q;
  assign ddiff = sx(dac_src) - sx(dac_zero_q);
  assign fs_code = ctrl_q.dac_range_2v ? DAC_FS_2V : DAC_FS_1V;

  always_comb begin
    dnum = $signed({{30{ddiff[33]}}, ddiff}) * $signed({48'h0, fs_code});
    dquot = (dac_span_q == '0) ? 64'sh0 : dnum / $signed({{32{dac_span_q[31]}}, dac_span_q});
    if (dquot > $signed({48'h0, fs_code})) begin
      dclamp = $signed(fs_code);
    end else if (dquot < -$signed({48'h0, fs_code})) begin
      dclamp = -$signed(fs_code);
    end else begin
      dclamp = dquot[15:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dac_tmr_q <= '0;
      dac_q <= 16'sh0000;
      dac_en_q <= 1'b0;
    end else begin
      dac_en_q <= ctrl_q.dac_enable;
      if (dac_tmr_q >= 32'(DAC_CYC - 1)) begin
        dac_tmr_q <= '0;
        dac_q <= ctrl_q.dac_enable ? dclamp : 16'sh0000;
      end else begin
        dac_tmr_q <= dac_tmr_q + 32'h0000_0001;
        if (!ctrl_q.dac_enable) begin
          dac_q <= 16'sh0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign upper_judgment_flag = upper_q;
  assign lower_judgment_flag = lower_q;
  assign stable = stable_q;
  assign display_value = disp_q;
  assign trig_pulse = trig_q;
  assign trig_pre_samples = pre_q;
  assign dac_enable = dac_en_q;
  assign dac_code = dac_q;

endmodule : ijht_top

/* bench/ijht_checker.sv */
// ijht_checker: port assertions for ijht_top
module ijht_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // samples and bus
  input wire logic sample_valid,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // results
  input wire logic upper_judgment_flag,
  input wire logic lower_judgment_flag,
  input wire logic trig_pulse,
  input wire logic dac_enable,
  input wire logic signed [15:0] dac_code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // bus answer after one wait state, low for one cycle only
  a_wait_one_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_read_data_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
    else $error("readdata moved outside a read");
  // judgment flags move only after a sample
  a_upper_after_sample: assert property (
    $changed(upper_judgment_flag) |-> $past(sample_valid, 2) || $past(sample_valid, 3)) else $error("upper moved");
  a_lower_after_sample: assert property (
    $changed(lower_judgment_flag) |-> $past(sample_valid, 2) || $past(sample_valid, 3)) else $error("lower moved");
  // trigger event is one cycle, two after its sample
  a_trig_one_cycle: assert property (trig_pulse |=> !trig_pulse)
    else $error("trigger pulse too long");
  a_trig_from_sample: assert property (trig_pulse |-> $past(sample_valid, 2))
    else $error("trigger without sample");
  // disabled output holds a zero code
  a_dac_off_zero: assert property (!dac_enable && !$past(dac_enable) |-> dac_code == 16'h0)
    else $error("code while disabled");
endmodule : ijht_checker

bind ijht_top ijht_checker ijht_checker_i (.ref_clk, .rst, .sample_valid, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .upper_judgment_flag, .lower_judgment_flag, .trig_pulse, .dac_enable, .dac_code);

/* bench/ijht_panel.sv */
// ijht_panel: operator push-button model
module ijht_panel (
  // clock
  input wire logic ref_clk,
  // button pulses
  output logic enter_button,
  output logic zero_button,
  output logic escape_button
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] btn_q = 3'h0;
  // 0 enter, 1 zero, 2 escape
  assign {escape_button, zero_button, enter_button} = btn_q;
  // one single-cycle pulse per long press
  task automatic press(input int k);
    @(posedge ref_clk);
    btn_q[k] <= 1'b1;
    @(posedge ref_clk);
    btn_q <= 3'h0;
    repeat (3) @(posedge ref_clk);
  endtask : press
endmodule : ijht_panel

/* bench/ijht_top_test.sv */
// ijht_top_test: self-checking bench for ijht_top
module ijht_top_test
  import ijht_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_valid = 1'b0;
  logic signed [31:0] sample_value = 32'sh0;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, upper_judgment_flag, lower_judgment_flag, stable, trig_pulse, dac_enable;
  logic enter_button, zero_button, escape_button;
  logic signed [31:0] display_value;
  logic [15:0] trig_pre_samples;
  logic signed [15:0] dac_code;
  logic [31:0] eq[$], mq[$];
  logic [7:0] aq[$];
  int mismatches = 0;
  int total_checks = 0;
  int hv[6] = '{21, 16, 15, 9, 14, 15};
  int hx[6] = '{1, 1, 0, 2, 2, 0};
  logic [31:0] tc[3] = '{32'h80, 32'h180, 32'h0};
  // design and button panel
  ijht_top #(.STAB_CYC(8), .DAC_CYC(4)) ijht_top_i (.ref_clk, .rst, .sample_valid, .sample_value,
    .enter_button, .zero_button, .escape_button, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .upper_judgment_flag, .lower_judgment_flag,
    .stable, .display_value, .trig_pulse, .trig_pre_samples, .dac_enable, .dac_code);
  ijht_panel ijht_panel_i (.ref_clk, .enter_button, .zero_button, .escape_button);
  always #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  // tasks
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] reg %h exp %h got %h", a, e, g);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
    @(posedge ref_clk);
    avs_byteenable <= b;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge ref_clk iff avs_waitrequest === 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    aq.push_back(a);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge ref_clk iff avs_waitrequest === 1'b0);
    avs_read <= 1'b0;
  endtask : rd
  task automatic smp(input int v);
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    sample_value <= v;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : smp
  // read results against the oldest note
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk(aq.pop_front(), eq.pop_front(), avs_readdata & mq.pop_front());
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    results();
  end
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hc7ce6fd7));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_HIGH_LIMIT, 32'h1);
    rd(8'h4c, 32'h0);
    wr(REG_LOW_STAGE, 32'ha);
    wr(REG_HIGH_STAGE, 32'ha);
    wr(REG_COMMAND, 32'h2);
    rd(REG_STATUS, 32'h40, 32'h40);
    rd(REG_HIGH_LIMIT, 32'h1);
    wr(REG_HIGH_STAGE, 32'h14);
    wr(REG_COMMAND, 32'h2);
    rd(REG_HIGH_LIMIT, 32'h14);
    wr(REG_HYST, 32'h5);
    for (int i = 0; i < 6; i++) begin
      smp(hv[i]);
      rd(REG_STATUS, hx[i], 32'h3);
    end
    wr(REG_HYST, 32'h0);
    smp(21 + $urandom % 80);
    rd(REG_STATUS, 32'h1, 32'h3);
    smp(20);
    rd(REG_STATUS, 32'h0, 32'h3);
    // zero capture, lock, limit and clear
    wr(REG_ZERO_LIMIT, 32'hff14, 4'h1);
    rd(REG_ZERO_LIMIT, 32'h14);
    wr(REG_CTRL, 32'h2);
    smp(50);
    ijht_panel_i.press(1);
    rd(REG_OFFSET, 32'h0);
    wr(REG_CTRL, 32'h3);
    ijht_panel_i.press(1);
    rd(REG_STATUS, 32'h20, 32'h20);
    rd(REG_OFFSET, 32'h0);
    smp(15);
    ijht_panel_i.press(1);
    smp(30);
    rd(REG_INDICATOR, 32'hf);
    wr(REG_COMMAND, 32'h1);
    rd(REG_OFFSET, 32'h0);
    // sample, peak and bottom hold, then zone retention
    smp(7);
    wr(REG_CTRL, 32'h4b);
    ijht_panel_i.press(0);
    smp(9);
    ijht_panel_i.press(2);
    rd(REG_HELD, 32'h0);
    ijht_panel_i.press(0);
    wr(REG_COMMAND, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(REG_CTRL, k ? 32'h1b : 32'h13);
      ijht_panel_i.press(0);
      smp(5);
      smp(12);
      smp(8);
      rd(REG_HELD, k ? 32'h5 : 32'hc);
      ijht_panel_i.press(2);
      smp(10);
      rd(REG_HELD, k ? 32'h8 : 32'ha);
      ijht_panel_i.press(0);
    end
    wr(REG_CTRL, 32'h33);
    ijht_panel_i.press(0);
    smp(12);
    ijht_panel_i.press(0);
    smp(3);
    rd(REG_HELD, 32'hc);
    rd(REG_STATUS, 32'h8, 32'h8);
    ijht_panel_i.press(2);
    rd(REG_STATUS, 32'h0, 32'h18);
    // rising, falling, disabled trigger
    wr(REG_TRIG_LEVEL, 32'ha);
    for (int k = 0; k < 3; k++) begin
      wr(REG_CTRL, tc[k]);
      smp(k == 1 ? 15 : 5);
      wr(REG_STATUS, 32'he0);
      smp(k == 1 ? 5 : 15);
      rd(REG_STATUS, k == 2 ? 32'h0 : 32'h80, 32'h80);
    end
    // analogue code scaling, range and enable
    wr(REG_DAC_ZERO, 32'h0);
    wr(REG_DAC_SPAN, 32'h64);
    wr(REG_STAB_WIDTH, 32'h5);
    wr(REG_CTRL, 32'h60c);
    ijht_panel_i.press(0);
    smp(100);
    repeat (12) @(posedge ref_clk);
    rd(REG_DAC_CODE, 32'h7fff);
    wr(REG_CTRL, 32'h200);
    smp(-100);
    repeat (12) @(posedge ref_clk);
    rd(REG_DAC_CODE, 32'hffffc001);
    wr(REG_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    rd(REG_DAC_CODE, 32'h0);
    rd(REG_STATUS, 32'h10, 32'h10);
    chk(REG_STATUS, 32'h1, 32'(stable));
    chk(REG_INDICATOR, 32'hffffff9c, display_value);
    // trigger position, out-of-range write ignored
    wr(REG_TRIG_POS, 32'h32);
    wr(REG_TRIG_POS, 32'h65);
    repeat (3) @(posedge ref_clk);
    chk(REG_TRIG_POS, 32'h1f4, {16'h0, trig_pre_samples});
    results();
  end
endmodule : ijht_top_test
